// >>> fwsr_ctrl.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - skip window check only under 50us spacing; ADD_GAP_CYC is unused, spacing is never timed
// - confirm acceptance by poll before window read
// - read window before and after each add
// - window high after add: maybe rejected
// - status reads use an in-sector address
// - two reads, equal toggle means done
// - fail seen while toggling: recheck toggle
// - after failure, issue reset command
module fwsr_ctrl #(
  parameter int AW = 22
) (
  input  wire logic          pclk,        // 10 MHz clock
  input  wire logic          presetn,     // async reset, low
  input  wire logic          psel,        // apb select
  input  wire logic          penable,     // apb enable
  input  wire logic          pwrite,      // apb direction
  input  wire logic [7:0]    paddr,       // apb address
  input  wire logic [31:0]   pwdata,      // apb write data
  output logic      [31:0]   prdata,      // apb read data
  output logic               pready,      // apb ready
  output logic               pslverr,     // apb error
  output logic [AW-1:0]      flash_addr,  // flash address
  input  wire logic [7:0]    flash_dq_i,  // flash data in
  output logic      [7:0]    flash_dq_o,  // flash data out
  output logic               flash_dq_oe, // high while driving dq
  output logic               flash_ce_n,  // chip enable, low
  output logic               flash_oe_n,  // output enable, low
  output logic               flash_we_n,  // write enable, low
  output logic               flash_rst_n, // hardware reset, low
  input  wire logic          ready_busy_out // flash ready pin
);
  initial begin
    if (AW < 1 || AW > 32) $error("fwsr_ctrl: AW out of range");
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  fwsr_pkg::fwsr_state_t st_q, st_d;
  logic [AW-1:0] addr_q;
  logic [7:0]    wdata_q, rdata_q, prev_q;
  logic [2:0]    cmd_q;
  logic [3:0]    cnt_q;
  logic [1:0]    rd_num_q;
  logic          busy_q, done_q, fail_q, win_q, rej_q, win_before_q, recheck_q;

  wire acc       = psel & penable & pready;
  wire wr_acc    = acc & pwrite;
  wire hit_ctrl  = paddr == fwsr_pkg::REG_CTRL;
  wire hit_addr  = paddr == fwsr_pkg::REG_ADDR;
  wire hit_wdata = paddr == fwsr_pkg::REG_WDATA;
  wire hit_stat  = paddr == fwsr_pkg::REG_STATUS;
  wire hit_rdata = paddr == fwsr_pkg::REG_RDATA;
  wire mapped    = hit_ctrl | hit_addr | hit_wdata | hit_stat | hit_rdata;
  wire start     = wr_acc & hit_ctrl & ~busy_q & (pwdata[2:0] != fwsr_pkg::CMD_NONE);
  wire [31:0] status_w = {26'h0, ready_busy_out, rej_q, win_q, fail_q, done_q, busy_q};
  wire [31:0] rd_mux = hit_ctrl  ? {29'h0, cmd_q} :
                       hit_addr  ? 32'(addr_q) :
                       hit_wdata ? {24'h0, wdata_q} :
                       hit_stat  ? status_w :
                       hit_rdata ? {24'h0, rdata_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= '0;
      wdata_q <= 8'h0;
    end else begin
      if (wr_acc & hit_addr & ~busy_q) addr_q <= pwdata[AW-1:0];
      if (wr_acc & hit_wdata & ~busy_q) wdata_q <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // flash cycle engine
  // ---------------------------------------------------------------
  wire rd_cmd    = (cmd_q != fwsr_pkg::CMD_WRITE);
  wire cyc_end   = cnt_q == 4'(rd_cmd ? fwsr_pkg::RD_CYC : fwsr_pkg::WR_CYC);
  wire gap_end   = cnt_q == 4'(fwsr_pkg::GAP_CYC);
  // compare the two latest captured reads; the bus is released outside a read
  wire have_two  = rd_num_q == 2'h2;
  wire tog_same  = prev_q[fwsr_pkg::DQ_TOG1] == rdata_q[fwsr_pkg::DQ_TOG1];
  wire fail_now  = rdata_q[fwsr_pkg::DQ_FAIL];
  wire poll_more = (cmd_q == fwsr_pkg::CMD_POLL) & (~have_two | (~tog_same & ~fail_now) |
                   (~tog_same & fail_now & ~recheck_q));
  wire win_more  = (cmd_q == fwsr_pkg::CMD_WINDOW) & ~have_two;

  always_comb begin
    st_d = st_q;
    case (st_q)
      fwsr_pkg::FW_IDLE: if (start) st_d = (pwdata[2:0] == fwsr_pkg::CMD_WRITE) ? fwsr_pkg::FW_WR : fwsr_pkg::FW_RD;
      fwsr_pkg::FW_RD:   if (cyc_end) st_d = fwsr_pkg::FW_GAP;
      fwsr_pkg::FW_WR:   if (cyc_end) st_d = fwsr_pkg::FW_GAP;
      fwsr_pkg::FW_GAP:  if (gap_end) st_d = fwsr_pkg::FW_EVAL;
      fwsr_pkg::FW_EVAL: st_d = (poll_more | win_more) ? fwsr_pkg::FW_RD : fwsr_pkg::FW_DONE;
      fwsr_pkg::FW_DONE: st_d = fwsr_pkg::FW_IDLE;
      default:           st_d = fwsr_pkg::FW_IDLE;
    endcase
  end

  wire in_rd = st_q == fwsr_pkg::FW_RD;
  wire in_wr = st_q == fwsr_pkg::FW_WR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fwsr_pkg::FW_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_q != st_d) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // pins: address held through the whole command so status reads stay in-sector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr  <= '0;
      flash_dq_o  <= 8'h0;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_rst_n <= 1'b0;
    end else begin
      flash_rst_n <= 1'b1;
      flash_addr  <= addr_q;
      flash_dq_o  <= wdata_q;
      flash_dq_oe <= (st_d == fwsr_pkg::FW_WR);
      flash_ce_n  <= ~((st_d == fwsr_pkg::FW_RD) | (st_d == fwsr_pkg::FW_WR));
      flash_oe_n  <= ~(st_d == fwsr_pkg::FW_RD);
      flash_we_n  <= ~(st_d == fwsr_pkg::FW_WR);
    end
  end

  // ---------------------------------------------------------------
  // result tracking
  // ---------------------------------------------------------------
  wire sample = in_rd & cyc_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= fwsr_pkg::CMD_NONE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      win_q <= 1'b0;
      rej_q <= 1'b0;
      win_before_q <= 1'b0;
      rd_num_q <= 2'h0;
      recheck_q <= 1'b0;
      prev_q <= 8'h0;
      rdata_q <= 8'h0;
    end else begin
      if (start) begin
        cmd_q     <= pwdata[2:0];
        busy_q    <= 1'b1;
        done_q    <= 1'b0;
        rd_num_q  <= 2'h0;
        recheck_q <= 1'b0;
        if (pwdata[2:0] == fwsr_pkg::CMD_WRITE) win_before_q <= win_q;
      end
      if (sample) begin
        prev_q  <= rdata_q;
        rdata_q <= flash_dq_i;
        if (!have_two) rd_num_q <= rd_num_q + 2'h1;
      end
      if (st_q == fwsr_pkg::FW_EVAL) begin
        if ((cmd_q == fwsr_pkg::CMD_POLL) & have_two & fail_now & ~tog_same) recheck_q <= 1'b1;
        if (cmd_q == fwsr_pkg::CMD_POLL & ~poll_more) fail_q <= ~tog_same;
        if (cmd_q == fwsr_pkg::CMD_WINDOW & have_two) begin
          win_q <= rdata_q[fwsr_pkg::DQ_WIN];
          rej_q <= rdata_q[fwsr_pkg::DQ_WIN] & ~win_before_q;
        end
      end
      if (st_q == fwsr_pkg::FW_DONE) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule : fwsr_ctrl

// >>> fwsr_ctrl_checker.sv
`timescale 1ns/1ps
module fwsr_ctrl_checker #(
  parameter int AW = 22
) (
  input wire logic pclk, presetn, psel, penable, pready, pslverr, // apb side
  input wire logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, flash_rst_n, // flash strobes
  input wire logic [AW-1:0] flash_addr // flash address
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_with_rdy_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rd_wr_apart_a: assert property (!(!flash_oe_n && !flash_we_n)) else $error("oe and we both low");
  we_drives_dq_a: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("write not driven");
  rd_len_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n[*3]) else $error("read pulse short");
  rd_gap_a: assert property ($rose(flash_oe_n) |-> flash_oe_n[*2]) else $error("read gap short");
  addr_hold_a: assert property (!flash_oe_n && !$fell(flash_oe_n) |-> $stable(flash_addr)) else $error("addr moved");
  rst_rel_a: assert property ($past(presetn) |-> flash_rst_n) else $error("flash reset held");
endmodule : fwsr_ctrl_checker
bind fwsr_ctrl fwsr_ctrl_checker #(.AW(AW)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .flash_dq_oe, .flash_rst_n, .flash_addr);

// >>> fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model #(
  parameter int WIN_RD = 4,
  parameter int OP_RD  = 6
) (
  input  wire logic       ce_n,  // chip enable, low
  input  wire logic       oe_n,  // output enable, low
  input  wire logic       we_n,  // write enable, low
  input  wire logic       rst_n, // hardware reset, low
  input  wire logic       stuck, // operation never finishes
  input  wire logic [7:0] din,   // data from host
  output logic      [7:0] dq,    // data to host
  output logic            rb     // ready pin
);
  logic [7:0] cmd = 8'h00, pd = 8'h00, last = 8'h00, v;
  logic       tg = 1'b0, t2 = 1'b0, ers = 1'b0;
  int         win = 0, run = 0;
  always @(we_n or din) if (!we_n) cmd = din;
  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n || cmd == 8'hF0) begin run = 0; win = 0; end
    else if (cmd == 8'h30 && (win > 0 || run == 0)) begin ers = 1; win = WIN_RD; run = OP_RD; end
    else if (cmd == 8'h10 && run == 0) begin ers = 1; win = 0; run = OP_RD; end
    else if (run == 0) begin ers = 0; pd = cmd; run = OP_RD; end
  end
  always @(negedge oe_n) begin
    if (run > 0) begin tg = ~tg; t2 = t2 ^ ers; end
    if (win > 0) win--; else if (run > 0 && !stuck) run--;
  end
  assign v = run > 0 ? {ers ? 1'b0 : ~pd[7], tg, stuck, 1'b0, win == 0, t2, 2'b00} : pd;
  always @(posedge oe_n) last = v;
  // released bus shows the inverse, never a stale value
  assign dq = (!oe_n && !ce_n) ? v : ~last;
  assign rb = run == 0;
endmodule : fwsr_flash_model

// >>> fwsr_pkg.sv
package fwsr_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ADDR    = 8'h04;
  localparam logic [7:0] REG_WDATA   = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_RDATA   = 8'h10;

  // ctrl register command codes (written to bits 2:0)
  localparam logic [2:0] CMD_NONE    = 3'h0;
  localparam logic [2:0] CMD_READ    = 3'h1;
  localparam logic [2:0] CMD_WRITE   = 3'h2;
  localparam logic [2:0] CMD_POLL    = 3'h3;
  localparam logic [2:0] CMD_WINDOW  = 3'h4;

  // status register bit positions
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_FAIL      = 2;
  localparam int ST_WIN_OPEN  = 3;
  localparam int ST_MAYBE_REJ = 4;
  localparam int ST_RB_IN     = 5;

  // status bit positions on the flash data bus
  localparam int DQ_POLL   = 7;
  localparam int DQ_TOG1   = 6;
  localparam int DQ_FAIL   = 5;
  localparam int DQ_WIN    = 3;
  localparam int DQ_TOG2   = 2;

  // flash bus timing
  localparam int CLK_NS     = 100;
  localparam int T_RC_NS    = 150;
  localparam int T_WP_NS    = 150;
  localparam int T_OEH_NS   = 10;
  localparam int RD_CYC     = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC    = ((T_OEH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_OEH_NS + CLK_NS - 1) / CLK_NS);
  localparam int ADD_GAP_US = 50;
  localparam int ADD_GAP_CYC = (ADD_GAP_US * 1000) / CLK_NS;

  typedef enum logic [5:0] {
    FW_IDLE  = 6'h01,
    FW_RD    = 6'h02,
    FW_WR    = 6'h04,
    FW_GAP   = 6'h08,
    FW_EVAL  = 6'h10,
    FW_DONE  = 6'h20
  } fwsr_state_t;
endpackage : fwsr_pkg

// >>> test_flash_write_status_reporting.sv
`timescale 1ns/1ps
module test_flash_write_status_reporting;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stuck = 0, slv;
  logic [7:0]  paddr = 8'h00, flash_dq_i, flash_dq_o, mdq;
  logic [31:0] pwdata = 32'h0, prdata, st;
  logic        pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n, ready_busy_out;
  logic [21:0] flash_addr;
  int          err_total = 0, total_checks = 0;
  always #50 pclk = ~pclk;
  fwsr_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_addr, .flash_dq_i, .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n,
    .ready_busy_out);
  fwsr_flash_model fm (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_n(flash_rst_n),
    .stuck(stuck), .din(flash_dq_o), .dq(mdq), .rb(ready_busy_out));
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : mdq;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; test_done(); end
    st = prdata; slv = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  // loads write data, issues a command and waits until busy clears
  task automatic op(input logic [2:0] c, input logic [7:0] wd);
    int n;
    apb(1, fwsr_pkg::REG_WDATA, {24'h0, wd});
    apb(1, fwsr_pkg::REG_CTRL, {29'h0, c});
    n = 0;
    do begin apb(0, fwsr_pkg::REG_STATUS, 32'h0); n++; end while (st[fwsr_pkg::ST_BUSY] !== 1'b0 && n < 300);
    if (n >= 300) begin err_total++; test_done(); end
  endtask : op
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h14, 32'h0); chk({slv, st}, {1'b1, 32'h0});
    apb(1, fwsr_pkg::REG_ADDR, 32'h123);
    op(fwsr_pkg::CMD_WRITE, 8'h80);
    op(fwsr_pkg::CMD_POLL, 8'h00); chk(st[2:1], 2'b01);
    op(fwsr_pkg::CMD_READ, 8'h00);
    apb(0, fwsr_pkg::REG_RDATA, 32'h0); chk(st[7:0], 8'h80);
    $display("program test ended");
    op(fwsr_pkg::CMD_WRITE, 8'h30);
    op(fwsr_pkg::CMD_WINDOW, 8'h00); chk(st[4:3], 2'b00);
    op(fwsr_pkg::CMD_WRITE, 8'h30);
    op(fwsr_pkg::CMD_WINDOW, 8'h00); chk(st[4:3], 2'b00);
    op(fwsr_pkg::CMD_WINDOW, 8'h00); chk(st[4:3], 2'b11);
    op(fwsr_pkg::CMD_POLL, 8'h00); chk(st[2:1], 2'b01);
    $display("sector erase test ended");
    stuck <= 1;
    op(fwsr_pkg::CMD_WRITE, 8'h10);
    op(fwsr_pkg::CMD_WINDOW, 8'h00); chk(st[3], 1'b1);
    op(fwsr_pkg::CMD_POLL, 8'h00); chk(st[2], 1'b1);
    op(fwsr_pkg::CMD_WRITE, 8'hF0);
    op(fwsr_pkg::CMD_READ, 8'h00);
    apb(0, fwsr_pkg::REG_RDATA, 32'h0); chk(st[7:0], 8'h80);
    $display("failure test ended");
    test_done();
  end
endmodule : test_flash_write_status_reporting
